// ==== logic/rtc_defines.svh ====
// Register offsets, reset values, field positions and counts of the RTC
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// Byte offsets on the register bus
`define OFF_INIT_KEY       8'h00
`define OFF_ACCESS_PW      8'h04
`define OFF_FREQ_TRIM      8'h08
`define OFF_TIME_LOAD      8'h0C
`define OFF_CAL_LOAD       8'h10
`define OFF_HOUR_FMT       8'h14
`define OFF_WEEKDAY        8'h18
`define OFF_TIME_ALARM     8'h1C
`define OFF_CAL_ALARM      8'h20
`define OFF_LEAP_YEAR      8'h24
`define OFF_IRQ_ENABLE     8'h28
`define OFF_IRQ_FLAG       8'h2C
`define OFF_TICK_SEL       8'h30

// Keys
`define INIT_KEY           32'hA5EB1357
`define ACCESS_PASSWORD    16'hA965

// Reset values
`define RST_FREQ_TRIM      12'h700
`define RST_CAL_LOAD       24'h050101
`define RST_HOUR_FMT       1'b1
`define RST_WEEKDAY        3'h6

// Implemented bits of the stored fields
`define TRIM_MASK          12'hF3F
`define TIME_MASK          22'h3F7F7F
`define CAL_MASK           24'hFF1F3F

// Field positions
`define OPEN_BIT           16
`define TICK_BIT           1
`define ALARM_BIT          0

// Bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

// Counts in RTC clocks
`define RTC_HZ             32768
`define ACCESS_WINDOW      512
`define WRITE_DELAY        2

`endif

// ==== logic/rtc_pkg.sv ====
// Bus carrier types of the RTC
package rtc_pkg;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

endpackage

// ==== logic/rtc_calendar_alarm_regs.sv ====
// Real-time clock with calendar, alarm, tick and gated register access
// Functional notes
// - Trim and alarm registers read as zero unless access is open.
// - Password field is write-only; magic value opens, other values close.
// - Access opens on password, closes after 512 RTC clocks or bad value.
// - Integer trim lives in bits 11:8, code stored with bits 7:6 cleared.
// - Time register holds BCD hour, minute, second digits at fixed fields.
// - Calendar register holds BCD year, month, day digits at fixed fields.
// - Bit 0 picks 24-hour or 12-hour scale; PM adds 20.
// - Weekday counts 0 Sunday to 6 Saturday, then wraps.
// - Time alarm uses the time register digit layout.
// - Calendar alarm uses the calendar register digit layout.
// - Read-only bit 0 shows whether current year is leap.
// - Enable bit 1 gates tick, bit 0 gates alarm.
// - Enabled tick sets its flag at the selected period.
// - Enabled alarm sets its flag when time and calendar match.
// - Tick select 0 gives 1 s, halving per step to 1/128 s.
// - Register writes land two RTC clocks after the bus write.
// - Block held in reset until init key written, then active until rst_n is asserted.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rtc_defines.svh"

module rtc_calendar_alarm_regs #(
  parameter int RTC_HZ    = `RTC_HZ,
  parameter int OPEN_CLKS = `ACCESS_WINDOW
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // RTC crystal clock, sampled as a pin
  input  wire logic             rtc_clk_pin,
  // Register bus
  input  wire rtc_pkg::axi_req_s bus_req,
  output wire rtc_pkg::axi_rsp_s bus_rsp,
  // Interrupt request
  output wire logic             irq
);

  localparam int CW = $clog2(RTC_HZ);
  localparam int OW = $clog2(OPEN_CLKS) + 1;

  typedef struct packed {
    logic [2:0]        sync;
    logic              pend;
    logic [7:0]        p_addr;
    logic [31:0]       p_data;
    logic [3:0]        p_strb;
    logic [1:0]        p_cnt;
    rtc_pkg::axi_rsp_s rsp;
    logic              active;
    logic              open;
    logic [OW-1:0]     open_cnt;
    logic [11:0]       trim;
    logic [21:0]       tload;
    logic [23:0]       cload;
    logic              fmt;
    logic [2:0]        wday;
    logic [21:0]       talarm;
    logic [23:0]       calarm;
    logic [1:0]        ien;
    logic [1:0]        flg;
    logic [2:0]        tsel;
    logic [CW-1:0]     sec_cnt;
    logic [CW-1:0]     tick_cnt;
    logic              irq;
  } st_s;

  localparam st_s RST = '{
    trim:    `RST_FREQ_TRIM,
    cload:   `RST_CAL_LOAD,
    fmt:     `RST_HOUR_FMT,
    wday:    `RST_WEEKDAY,
    default: '0
  };

  st_s  s_q;
  st_s  s_d;
  logic rtc_edge;
  logic apply;
  logic sec_step;
  logic day_roll;
  logic tick_set;
  logic alarm_set;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0}
                            : {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Years are 20xY, so divisible-by-four is the whole test
  function automatic logic leap_year(input logic [7:0] y);
    if (y[4])
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] month_end(input logic [7:0] mo,
                                           input logic       lp);
    case (mo)
      8'h02:                      return lp ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default:                    return 8'h31;
    endcase
  endfunction

  function automatic logic [7:0] hour_next(input logic [7:0] h,
                                           input logic       f);
    if (f)
      return (h == 8'h23) ? 8'h00 : bcd_inc(h);
    case (h)
      8'h11:   return 8'h32;
      8'h31:   return 8'h12;
      8'h12:   return 8'h01;
      8'h32:   return 8'h21;
      default: return bcd_inc(h);
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a <= `OFF_TICK_SEL) && (a[1:0] == 2'h0);
  endfunction

  // Gated reads hide trim, alarms and tick select while closed
  function automatic logic [31:0] reg_val(input st_s        s,
                                          input logic [7:0] a,
                                          input logic       gate);
    logic hide;
    hide = gate && !s.open;
    case (a)
      `OFF_INIT_KEY:   return {31'h0, s.active};
      `OFF_ACCESS_PW:  return {15'h0, s.open, 16'h0};
      `OFF_FREQ_TRIM:  return hide ? 32'h0 : {20'h0, s.trim};
      `OFF_TIME_LOAD:  return {10'h0, s.tload};
      `OFF_CAL_LOAD:   return {8'h0, s.cload};
      `OFF_HOUR_FMT:   return {31'h0, s.fmt};
      `OFF_WEEKDAY:    return {29'h0, s.wday};
      `OFF_TIME_ALARM: return hide ? 32'h0 : {10'h0, s.talarm};
      `OFF_CAL_ALARM:  return hide ? 32'h0 : {8'h0, s.calarm};
      `OFF_LEAP_YEAR:  return {31'h0, leap_year(s.cload[23:16])};
      `OFF_IRQ_ENABLE: return {30'h0, s.ien};
      `OFF_IRQ_FLAG:   return {30'h0, s.flg};
      `OFF_TICK_SEL:   return hide ? 32'h0 : {29'h0, s.tsel};
      default:         return 32'h0;
    endcase
  endfunction

  assign rtc_edge = s_q.sync[1] & ~s_q.sync[2];
  assign apply    = s_q.pend && rtc_edge &&
                    (s_q.p_cnt == 2'(`WRITE_DELAY - 1));
  assign sec_step = rtc_edge && s_q.active &&
                    (s_q.sec_cnt == CW'(RTC_HZ - 1));

  always_comb begin
    logic [7:0]  s8;
    logic [7:0]  m8;
    logic [7:0]  h8;
    logic [7:0]  d8;
    logic [7:0]  mo8;
    logic [7:0]  y8;
    logic [31:0] msk;
    logic [31:0] nv;
    logic        wok;
    s8        = {1'b0, s_q.tload[6:0]};
    m8        = {1'b0, s_q.tload[14:8]};
    h8        = {2'b0, s_q.tload[21:16]};
    d8        = {2'b0, s_q.cload[5:0]};
    mo8       = {3'b0, s_q.cload[12:8]};
    y8        = s_q.cload[23:16];
    msk       = {{8{s_q.p_strb[3]}}, {8{s_q.p_strb[2]}},
                 {8{s_q.p_strb[1]}}, {8{s_q.p_strb[0]}}};
    nv        = (reg_val(s_q, s_q.p_addr, 1'b0) & ~msk) |
                (s_q.p_data & msk);
    wok       = s_q.active && (s_q.open ||
                (s_q.p_addr == `OFF_ACCESS_PW) ||
                (s_q.p_addr == `OFF_HOUR_FMT) ||
                (s_q.p_addr == `OFF_IRQ_ENABLE) ||
                (s_q.p_addr == `OFF_IRQ_FLAG));
    day_roll  = 1'b0;
    tick_set  = 1'b0;
    alarm_set = 1'b0;
    s_d       = s_q;
    s_d.sync  = {s_q.sync[1:0], rtc_clk_pin};

    // Write channel: address and data are taken together
    s_d.rsp.awready = 1'b0;
    s_d.rsp.wready  = 1'b0;
    if (s_q.rsp.bvalid && bus_req.bready)
      s_d.rsp.bvalid = 1'b0;
    if (s_q.rsp.awready && bus_req.awvalid && bus_req.wvalid) begin
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = mapped(bus_req.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      if (mapped(bus_req.awaddr)) begin
        s_d.pend   = 1'b1;
        s_d.p_addr = bus_req.awaddr;
        s_d.p_data = bus_req.wdata;
        s_d.p_strb = bus_req.wstrb;
        s_d.p_cnt  = 2'h0;
      end
    end else if (bus_req.awvalid && bus_req.wvalid && !s_q.pend &&
                 !s_q.rsp.bvalid) begin
      // One write in flight; the next waits for the RTC side
      s_d.rsp.awready = 1'b1;
      s_d.rsp.wready  = 1'b1;
    end

    // Read channel
    s_d.rsp.arready = 1'b0;
    if (s_q.rsp.rvalid && bus_req.rready)
      s_d.rsp.rvalid = 1'b0;
    if (s_q.rsp.arready && bus_req.arvalid) begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata  = reg_val(s_q, bus_req.araddr, 1'b1);
      s_d.rsp.rresp  = mapped(bus_req.araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bus_req.arvalid && !s_q.rsp.rvalid)
      s_d.rsp.arready = 1'b1;

    // Access window closes by itself
    if (rtc_edge && s_q.open) begin
      s_d.open_cnt = s_q.open_cnt + OW'(1);
      if (s_q.open_cnt == OW'(OPEN_CLKS - 1))
        s_d.open = 1'b0;
    end

    if (rtc_edge && s_q.active) begin
      s_d.sec_cnt = s_q.sec_cnt + CW'(1);
      // Greater-or-equal survives a shorter period chosen mid-count
      if (s_q.tick_cnt >= CW'((RTC_HZ >> s_q.tsel) - 1)) begin
        s_d.tick_cnt = '0;
        tick_set     = s_q.ien[`TICK_BIT];
      end else
        s_d.tick_cnt = s_q.tick_cnt + CW'(1);
    end

    if (sec_step) begin
      s_d.sec_cnt = '0;
      if (s8 == 8'h59) begin
        s8 = 8'h00;
        if (m8 == 8'h59) begin
          m8       = 8'h00;
          day_roll = s_q.fmt ? (h8 == 8'h23) : (h8 == 8'h31);
          h8       = hour_next(h8, s_q.fmt);
        end else
          m8 = bcd_inc(m8);
      end else
        s8 = bcd_inc(s8);
      if (day_roll) begin
        if (d8 == month_end(mo8, leap_year(y8))) begin
          d8 = 8'h01;
          if (mo8 == 8'h12) begin
            mo8 = 8'h01;
            y8  = (y8 == 8'h99) ? 8'h00 : bcd_inc(y8);
          end else
            mo8 = bcd_inc(mo8);
        end else
          d8 = bcd_inc(d8);
        s_d.wday = (s_q.wday == 3'h6) ? 3'h0 : s_q.wday + 3'h1;
      end
      s_d.tload = {h8[5:0], 1'b0, m8[6:0], 1'b0, s8[6:0]};
      s_d.cload = {y8, 3'h0, mo8[4:0], 2'h0, d8[5:0]};
      alarm_set = s_q.ien[`ALARM_BIT] &&
                  (s_d.tload == s_q.talarm) &&
                  (s_d.cload == s_q.calarm);
    end

    // Delayed register update; a load overrides the count
    if (s_q.pend && rtc_edge)
      s_d.p_cnt = s_q.p_cnt + 2'h1;
    if (apply) begin
      s_d.pend = 1'b0;
      case (s_q.p_addr)
        `OFF_INIT_KEY:
          if (nv == `INIT_KEY)
            s_d.active = 1'b1;
        `OFF_ACCESS_PW:
          if (wok) begin
            s_d.open     = (nv[15:0] == `ACCESS_PASSWORD);
            s_d.open_cnt = '0;
          end
        `OFF_FREQ_TRIM:
          if (wok)
            s_d.trim = nv[11:0] & `TRIM_MASK;
        `OFF_TIME_LOAD:
          if (wok)
            s_d.tload = nv[21:0] & `TIME_MASK;
        `OFF_CAL_LOAD:
          if (wok)
            s_d.cload = nv[23:0] & `CAL_MASK;
        `OFF_HOUR_FMT:
          if (wok)
            s_d.fmt = nv[0];
        `OFF_WEEKDAY:
          if (wok)
            s_d.wday = nv[2:0];
        `OFF_TIME_ALARM:
          if (wok)
            s_d.talarm = nv[21:0] & `TIME_MASK;
        `OFF_CAL_ALARM:
          if (wok)
            s_d.calarm = nv[23:0] & `CAL_MASK;
        `OFF_IRQ_ENABLE:
          if (wok)
            s_d.ien = nv[1:0];
        `OFF_IRQ_FLAG:
          if (wok)
            s_d.flg = s_q.flg &
                      ~(s_q.p_data[1:0] & {2{s_q.p_strb[0]}});
        `OFF_TICK_SEL:
          if (wok)
            s_d.tsel = nv[2:0];
        default: ;
      endcase
    end

    // Hardware set wins over a clear in the same cycle
    if (tick_set)
      s_d.flg[`TICK_BIT] = 1'b1;
    if (alarm_set)
      s_d.flg[`ALARM_BIT] = 1'b1;
    s_d.irq = |(s_d.flg & s_d.ien);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      s_q <= RST;
    else if (ce)
      s_q <= s_d;
  end

  assign bus_rsp = s_q.rsp;
  assign irq     = s_q.irq;

  default clocking cb @(posedge clock iff ce);
  endclocking
  default disable iff (!rst_n);

  sequence s_read_trim_closed;
    bus_req.arvalid && s_q.rsp.arready && !s_q.open &&
    (bus_req.araddr == `OFF_FREQ_TRIM);
  endsequence

  sequence s_write_take;
    bus_req.awvalid && bus_req.wvalid && s_q.rsp.awready &&
    mapped(bus_req.awaddr);
  endsequence

  sequence s_pw_write(logic good);
    apply && s_q.active && (s_q.p_addr == `OFF_ACCESS_PW) &&
    (s_q.p_strb[1:0] == 2'h3) &&
    ((s_q.p_data[15:0] == `ACCESS_PASSWORD) == good);
  endsequence

  a_trim_read_gate: assert property (s_read_trim_closed |=>
    s_q.rsp.rvalid && (s_q.rsp.rdata == 32'h0))
    else $error("trim read back while access closed");
  a_pw_rejects: assert property (s_pw_write(1'b0) |=> !s_q.open)
    else $error("bad password left access open");
  a_pw_opens: assert property (s_pw_write(1'b1) |=>
    s_q.open ##1 (s_q.open || rtc_edge))
    else $error("good password did not open access");
  a_open_timeout: assert property (s_q.open && rtc_edge &&
    (s_q.open_cnt == OW'(OPEN_CLKS - 1)) && !apply |=> !s_q.open)
    else $error("access window outlived its count");
  a_write_delay: assert property (s_write_take |=>
    s_q.pend && (s_q.p_cnt == 2'h0) && !apply)
    else $error("write landed without the RTC delay");
  a_weekday_wrap: assert property (day_roll && !apply |=>
    s_q.wday == (($past(s_q.wday) == 3'h6) ? 3'h0
                                           : $past(s_q.wday) + 3'h1))
    else $error("weekday did not step");
  a_alarm_cause: assert property ($rose(s_q.flg[`ALARM_BIT]) &&
    !$past(apply) |-> $past(s_q.ien[`ALARM_BIT]) &&
    (s_q.tload == s_q.talarm) && (s_q.cload == s_q.calarm))
    else $error("alarm flag set without a match");
  a_tick_cause: assert property ($rose(s_q.flg[`TICK_BIT]) |->
    $past(s_q.ien[`TICK_BIT]) && $past(rtc_edge) && $past(s_q.active))
    else $error("tick flag set without an enabled tick");
  a_flag_clear: assert property (apply && s_q.active &&
    (s_q.p_addr == `OFF_IRQ_FLAG) && s_q.p_data[1] && s_q.p_strb[0] &&
    !tick_set |=> !s_q.flg[`TICK_BIT])
    else $error("write of one did not clear tick flag");
  a_pm_noon: assert property (sec_step && !s_q.fmt && !apply &&
    (s_q.tload == 22'h115959) |=> (s_q.tload[21:16] == 6'h32))
    else $error("12-hour scale missed PM twelve");
  a_init_sticky: assert property (s_q.active |=> s_q.active)
    else $error("block fell back into reset");
  a_held_reset: assert property (!s_q.active |=>
    $stable(s_q.tload) && $stable(s_q.cload))
    else $error("counters moved before init key");
  a_leap_read: assert property (bus_req.arvalid &&
    s_q.rsp.arready && (bus_req.araddr == `OFF_LEAP_YEAR) |=>
    s_q.rsp.rdata == {31'h0, leap_year($past(s_q.cload[23:16]))})
    else $error("leap indicator wrong");

endmodule

// ==== sim/rtc_calendar_alarm_regs_tb.sv ====
// Self-checking bench for the RTC register block
`timescale 1ns/1ps
module rtc_calendar_alarm_regs_tb;
  localparam int HZ  = 128;
  localparam int WIN = 8;
  localparam int RP  = 16;  // System cycles per RTC period
  localparam int LIM = 60000;

  logic              clock       = 1'b0;
  logic              rst_n       = 1'b0;
  logic              ce          = 1'b1;
  logic              rtc_clk_pin = 1'b0;
  rtc_pkg::axi_req_s bus_req     = '0;
  rtc_pkg::axi_rsp_s bus_rsp;
  logic              irq;
  int                err_count   = 0;
  int                comparisons = 0;
  int                cyc         = 0;
  logic [31:0]       rd;
  logic [1:0]        rs;

  rtc_calendar_alarm_regs #(
    .RTC_HZ    (HZ),
    .OPEN_CLKS (WIN)
  ) rtc_calendar_alarm_regs_inst (
    .clock       (clock),
    .rst_n       (rst_n),
    .ce          (ce),
    .rtc_clk_pin (rtc_clk_pin),
    .bus_req     (bus_req),
    .bus_rsp     (bus_rsp),
    .irq         (irq)
  );

  always #2 clock = ~clock;

  // RTC pin made from the system clock, far faster than real time
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc % (RP / 2) == RP / 2 - 1)
      rtc_clk_pin <= ~rtc_clk_pin;
    if (cyc == LIM) begin
      err_count++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string m);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, m, seen, exp);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done = 1'b0;
    logic w_done  = 1'b0;
    @(posedge clock);
    bus_req.awvalid <= 1'b1;
    bus_req.awaddr  <= a;
    bus_req.wvalid  <= 1'b1;
    bus_req.wdata   <= d;
    bus_req.wstrb   <= 4'hF;
    bus_req.bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (!aw_done && bus_rsp.awready === 1'b1) begin
        aw_done = 1'b1;
        bus_req.awvalid <= 1'b0;
      end
      if (!w_done && bus_rsp.wready === 1'b1) begin
        w_done = 1'b1;
        bus_req.wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    do @(posedge clock); while (bus_rsp.bvalid !== 1'b1);
    rs = bus_rsp.bresp;
    bus_req.bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clock);
    bus_req.arvalid <= 1'b1;
    bus_req.araddr  <= a;
    bus_req.rready  <= 1'b1;
    do @(posedge clock); while (bus_rsp.arready !== 1'b1);
    bus_req.arvalid <= 1'b0;
    do @(posedge clock); while (bus_rsp.rvalid !== 1'b1);
    rd = bus_rsp.rdata;
    rs = bus_rsp.rresp;
    bus_req.rready <= 1'b0;
  endtask

  // Long enough for two RTC edges plus the pin synchroniser
  task automatic settle;
    repeat (3 * RP) @(posedge clock);
  endtask

  task automatic t_reset;
    logic [7:0]  a [8] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
                           8'h24, 8'h2C};
    logic [31:0] e [8] = '{32'h0, 32'h0, 32'h0, 32'h00050101, 32'h1,
                           32'h6, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++) begin
      rdr(a[i]);
      chk(rd, e[i], "reset value");
    end
    wr(8'h14, 32'h0);
    settle();
    rdr(8'h14);
    chk(rd, 32'h1, "write before init");
    rdr(8'h34);
    chk({30'h0, rs}, 32'h2, "unmapped read");
    wr(8'h34, 32'h1);
    chk({30'h0, rs}, 32'h2, "unmapped write");
    $display("t_reset done");
  endtask

  task automatic t_init;
    wr(8'h00, 32'hA5EB1357);
    chk({30'h0, rs}, 32'h0, "write okay");
    settle();
    rdr(8'h00);
    chk(rd, 32'h1, "active");
    chk({30'h0, rs}, 32'h0, "read okay");
    wr(8'h14, 32'h0);
    rdr(8'h14);
    chk(rd, 32'h1, "early read");
    settle();
    rdr(8'h14);
    chk(rd, 32'h0, "landed");
    wr(8'h14, 32'h1);
    settle();
    $display("t_init done");
  endtask

  task automatic t_access;
    rdr(8'h08);
    chk(rd, 32'h0, "trim closed");
    wr(8'h04, 32'h0000A965);
    settle();
    rdr(8'h04);
    chk(rd, 32'h00010000, "open");
    rdr(8'h08);
    chk(rd, 32'h00000700, "trim open");
    wr(8'h08, 32'h00000C27);
    settle();
    rdr(8'h08);
    chk(rd, 32'h00000C27, "trim fields");
    wr(8'h04, 32'h00001234);
    settle();
    rdr(8'h04);
    chk(rd, 32'h0, "bad password");
    rdr(8'h08);
    chk(rd, 32'h0, "trim hidden");
    wr(8'h04, 32'h0000A965);
    settle();
    repeat ((WIN + 2) * RP) @(posedge clock);
    rdr(8'h04);
    chk(rd, 32'h0, "window expiry");
    $display("t_access done");
  endtask

  task automatic t_roll;
    int n = 0;
    wr(8'h04, 32'h0000A965);
    wr(8'h10, 32'h00240228);
    wr(8'h04, 32'h0000A965);
    wr(8'h18, 32'h6);
    wr(8'h04, 32'h0000A965);
    wr(8'h0C, 32'h00235959);
    settle();
    do begin
      repeat (RP) @(posedge clock);
      rdr(8'h0C);
      n++;
    end while (rd !== 32'h0 && n < 200);
    chk(rd, 32'h0, "midnight");
    rdr(8'h10);
    chk(rd, 32'h00240229, "leap day");
    rdr(8'h18);
    chk(rd, 32'h0, "weekday wrap");
    rdr(8'h24);
    chk(rd, 32'h1, "leap flag");
    $display("t_roll done");
  endtask

  task automatic t_alarm;
    int n = 0;
    wr(8'h28, 32'h1);
    wr(8'h04, 32'h0000A965);
    wr(8'h20, 32'h00240229);
    wr(8'h04, 32'h0000A965);
    wr(8'h1C, 32'h00120001);
    wr(8'h04, 32'h0000A965);
    settle();
    rdr(8'h1C);
    chk(rd, 32'h00120001, "time alarm");
    rdr(8'h20);
    chk(rd, 32'h00240229, "date alarm");
    wr(8'h04, 32'h0000A965);
    wr(8'h0C, 32'h00120000);
    while (irq !== 1'b1 && n < 3 * HZ * RP) begin
      @(posedge clock);
      n++;
    end
    chk({31'h0, irq}, 32'h1, "alarm irq");
    rdr(8'h0C);
    chk(rd, 32'h00120001, "alarm time");
    rdr(8'h2C);
    chk(rd, 32'h1, "alarm flag");
    wr(8'h2C, 32'h0);
    settle();
    rdr(8'h2C);
    chk(rd, 32'h1, "write zero");
    wr(8'h2C, 32'h1);
    settle();
    rdr(8'h2C);
    chk(rd, 32'h0, "write one");
    chk({31'h0, irq}, 32'h0, "irq low");
    $display("t_alarm done");
  endtask

  task automatic t_tick;
    wr(8'h28, 32'h0);
    wr(8'h04, 32'h0000A965);
    wr(8'h30, 32'h7);
    settle();
    rdr(8'h2C);
    chk(rd, 32'h0, "tick disabled");
    wr(8'h28, 32'h2);
    settle();
    rdr(8'h2C);
    chk(rd, 32'h2, "tick flag");
    chk({31'h0, irq}, 32'h1, "tick irq");
    wr(8'h28, 32'h0);
    wr(8'h2C, 32'h2);
    settle();
    rdr(8'h2C);
    chk(rd, 32'h0, "tick cleared");
    chk({31'h0, irq}, 32'h0, "tick irq off");
    $display("t_tick done");
  endtask

  task automatic t_12h;
    int n = 0;
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h0000A965);
    wr(8'h0C, 32'h00115959);
    settle();
    do begin
      repeat (RP) @(posedge clock);
      rdr(8'h0C);
      n++;
    end while (rd === 32'h00115959 && n < 200);
    chk(rd, 32'h00320000, "noon in 12h");
    // Clock enable low must freeze the seconds count
    @(posedge clock);
    ce <= 1'b0;
    repeat (3 * HZ * RP) @(posedge clock);
    ce <= 1'b1;
    rdr(8'h0C);
    chk(rd, 32'h00320000, "frozen by ce");
    $display("t_12h done");
  endtask

  // Mid-run reset drops the block back out of the active state
  task automatic t_rst;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rdr(8'h00);
    chk(rd, 32'h0, "active cleared");
    rdr(8'h0C);
    chk(rd, 32'h0, "time reset");
    rdr(8'h10);
    chk(rd, 32'h00050101, "calendar reset");
    $display("t_rst done");
  endtask

  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_init();
    t_access();
    t_roll();
    t_alarm();
    t_tick();
    t_12h();
    t_rst();
    test_done();
  end
endmodule
